// file: rtl/dpt_trip.sv
// Drive protection: external trip, overload, reference loss, brake duty
//
// Operation
// RULE1: Each of eight input terminals takes a function code 0 to 27.
// RULE2: Code 18 selects normally-open trip, code 19 normally-closed trip.
// RULE3: Normally-open trip input closed flags fault and cuts output.
// RULE4: Normally-closed trip input open flags fault and cuts output.
// RULE5: Output current above inverter rated current raises overload trip.
// RULE6: Output or relay select 6 signals the overload trip.
// RULE7: Loss criterion 0 off, 1 below half minimum, 2 below minimum.
// RULE8: Voltage-plus-current source is lost if either input is low.
// RULE9: Loss detection covers voltage, current and communication source.
// RULE10: Reaction applies after wait time, 0.1 to 120 s, default 1.0.
// RULE11: Reaction 0 continue, 1 free run, 2 decelerate, 3 preset.
// RULE12: Preset reaction selects preset frequency so operation continues.
// RULE13: Output or relay select 11 signals loss of frequency command.
// RULE14: Duty limit select 0 no limit, 1 limit to duty percentage.
// RULE15: Duty percentage for one sequence, 0 to 30, default 10.
// RULE16: Resistor enable never stays on longer than 15 s.
// RULE17: Duty is decel time over whole sequence time times 100.
// RULE18: Trip faults and output cut hold until fault reset.
// RULE19: Trip inputs are synchronised and debounced before use.
`timescale 1ns/1ps
module dpt_trip #(
  parameter int N_IN = 8,
  parameter int AW = 12,
  parameter int CW = 16,
  parameter int TICK_CYC = dpt_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Terminals and measurements
  input wire logic [N_IN-1:0] terminal_in,
  input wire logic [CW-1:0] output_current,
  input wire logic [CW-1:0] rated_current,
  input wire logic [AW-1:0] analog_voltage_reference,
  input wire logic [AW-1:0] analog_current_reference,
  input wire logic comm_reference_lost,
  // Braking resistor
  input wire logic sequence_start,
  input wire logic decel_active,
  input wire logic brake_request,
  output logic resistor_enable,
  // Drive control and alarms
  output logic inverter_output_enable,
  output logic decel_stop_request,
  output logic preset_freq_select,
  output logic fault_display,
  output logic multifunction_digital_output,
  output logic multifunction_relay_output
);
  import dpt_pkg::*;

  // ****************
  // Register bus
  // ****************
  logic ack_q, ack_d, req, wr_en;
  logic [31:0] rdata_q, rdata_d;
  logic [4:0] func_q [N_IN], func_d [N_IN];
  logic [4:0] digital_output_function_select, relay_function_select;
  logic [4:0] out_sel_q, out_sel_d, rly_sel_q, rly_sel_d;
  logic [1:0] crit_q, crit_d, mode_q, mode_d, src_q, src_d;
  logic [10:0] wait_q, wait_d;
  logic [AW-1:0] vmin_q, vmin_d, imin_q, imin_d;
  logic [4:0] pct_q, pct_d;
  logic lim_q, lim_d, fault_rst;
  logic [31:0] status;
  logic ext_trip_q, ovl_trip_q, loss_trip_q, loss_q, brake_on_q;

  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_en = avs_write & ack_q;
  assign avs_readdata = rdata_q;
  assign fault_rst = wr_en && avs_address == ADDR_CTRL &&
                     avs_writedata[CTRL_FAULT_RST];
  assign digital_output_function_select = out_sel_q;
  assign relay_function_select = rly_sel_q;
  assign status = {24'h0, brake_on_q, loss_q, preset_freq_select,
                   decel_stop_request, inverter_output_enable,
                   loss_trip_q, ovl_trip_q, ext_trip_q};

  always_comb begin
    ack_d = req & ~ack_q;
    rdata_d = rdata_q;
    func_d = func_q;
    out_sel_d = out_sel_q;
    rly_sel_d = rly_sel_q;
    crit_d = crit_q;
    mode_d = mode_q;
    src_d = src_q;
    wait_d = wait_q;
    vmin_d = vmin_q;
    imin_d = imin_q;
    pct_d = pct_q;
    lim_d = lim_q;
    if (avs_read && !ack_q) begin
      rdata_d = 32'h0;
      case (avs_address)
        ADDR_CTRL: rdata_d = {18'h0, src_q, 2'h0, mode_q, 2'h0, crit_q,
                              4'h0};
        ADDR_INFUNC_LO: for (int i = 0; i < 4; i++)
          rdata_d[i*FUNC_STRIDE +: 5] = func_q[i];
        ADDR_INFUNC_HI: for (int i = 4; i < N_IN; i++)
          rdata_d[(i-4)*FUNC_STRIDE +: 5] = func_q[i];
        ADDR_OUTSEL: rdata_d = {19'h0, rly_sel_q, 3'h0, out_sel_q};
        ADDR_LOSS_WAIT: rdata_d = {21'h0, wait_q};
        ADDR_ANA_MIN: begin
          rdata_d[AW-1:0] = vmin_q;
          rdata_d[ANA_CUR_LSB +: AW] = imin_q;
        end
        ADDR_BRAKE: rdata_d = {23'h0, lim_q, 3'h0, pct_q};
        ADDR_STATUS: rdata_d = status;
        default: rdata_d = 32'h0;
      endcase
    end
    if (wr_en) begin
      case (avs_address)
        ADDR_CTRL: begin
          crit_d = avs_writedata[CTRL_CRIT_LSB +: 2];
          mode_d = avs_writedata[CTRL_MODE_LSB +: 2];
          src_d = avs_writedata[CTRL_SRC_LSB +: 2];
        end
        ADDR_INFUNC_LO, ADDR_INFUNC_HI: for (int i = 0; i < N_IN; i++) begin
          // Out-of-range codes are ignored, keeping the old function
          if ((i < 4) == (avs_address == ADDR_INFUNC_LO) &&
              avs_writedata[(i%4)*FUNC_STRIDE +: 5] <= FUNC_MAX)
            func_d[i] = avs_writedata[(i%4)*FUNC_STRIDE +: 5]; // [RULE1]
        end
        ADDR_OUTSEL: begin
          out_sel_d = avs_writedata[4:0];
          rly_sel_d = avs_writedata[OUTSEL_RELAY_LSB +: 5];
        end
        ADDR_LOSS_WAIT:
          if (avs_writedata[10:0] >= WAIT_MIN &&
              avs_writedata[10:0] <= WAIT_MAX &&
              avs_writedata[31:11] == 21'h0)
            wait_d = avs_writedata[10:0]; // [RULE10]
        ADDR_ANA_MIN: begin
          vmin_d = avs_writedata[AW-1:0];
          imin_d = avs_writedata[ANA_CUR_LSB +: AW];
        end
        ADDR_BRAKE: begin
          lim_d = avs_writedata[BRAKE_LIMIT_BIT]; // [RULE14]
          if (avs_writedata[4:0] <= PCT_MAX)
            pct_d = avs_writedata[4:0]; // [RULE15]
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
      for (int i = 0; i < N_IN; i++)
        func_q[i] <= 5'h00;
      out_sel_q <= 5'h00;
      rly_sel_q <= 5'h00;
      crit_q <= 2'h0;
      mode_q <= 2'h0;
      src_q <= 2'h0;
      wait_q <= WAIT_RESET;
      vmin_q <= '0;
      imin_q <= '0;
      pct_q <= PCT_RESET;
      lim_q <= 1'b1;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      func_q <= func_d;
      out_sel_q <= out_sel_d;
      rly_sel_q <= rly_sel_d;
      crit_q <= crit_d;
      mode_q <= mode_d;
      src_q <= src_d;
      wait_q <= wait_d;
      vmin_q <= vmin_d;
      imin_q <= imin_d;
      pct_q <= pct_d;
      lim_q <= lim_d;
    end
  end

  // ****************
  // Trip inputs and latches
  // ****************
  logic [N_IN-1:0] clean, trip_hit;
  genvar g;
  generate
    for (g = 0; g < N_IN; g++) begin : g_in
      dpt_debounce u_db (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .raw_in(terminal_in[g]),
        .clean_out(clean[g])
      ); // [RULE19]
      assign trip_hit[g] = // [RULE2]
        (func_q[g] == FUNC_TRIP_NO && clean[g]) || // [RULE3]
        (func_q[g] == FUNC_TRIP_NC && !clean[g]); // [RULE4]
    end
  endgenerate

  logic ovl_now, loss_fire;
  logic ext_trip_d, ovl_trip_d, loss_trip_d;
  assign ovl_now = output_current > rated_current; // [RULE5]

  // Set wins over a simultaneous fault reset
  always_comb begin
    ext_trip_d = (ext_trip_q & ~fault_rst) | (|trip_hit); // [RULE18]
    ovl_trip_d = (ovl_trip_q & ~fault_rst) | ovl_now; // [RULE18]
    loss_trip_d = (loss_trip_q & ~fault_rst) |
                  (loss_fire && mode_q == DPT_REACT_FREERUN); // [RULE11]
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ext_trip_q <= 1'b0;
      ovl_trip_q <= 1'b0;
      loss_trip_q <= 1'b0;
    end else begin
      ext_trip_q <= ext_trip_d;
      ovl_trip_q <= ovl_trip_d;
      loss_trip_q <= loss_trip_d;
    end
  end

  // ****************
  // Reference loss
  // ****************
  logic tick;
  logic [31:0] tick_q, tick_d;
  logic [10:0] lwait_q, lwait_d;
  logic loss_d, v_low, i_low, ref_missing;

  always_comb begin
    v_low = 1'b0;
    i_low = 1'b0;
    case (dpt_crit_e'(crit_q))
      DPT_CRIT_HALF: begin
        v_low = analog_voltage_reference < (vmin_q >> 1); // [RULE7]
        i_low = analog_current_reference < (imin_q >> 1);
      end
      DPT_CRIT_BELOW: begin
        v_low = analog_voltage_reference < vmin_q; // [RULE7]
        i_low = analog_current_reference < imin_q;
      end
      default: ;
    endcase
    case (dpt_src_e'(src_q))
      DPT_SRC_VOLT: ref_missing = v_low; // [RULE9]
      DPT_SRC_CURR: ref_missing = i_low; // [RULE9]
      DPT_SRC_BOTH: ref_missing = v_low | i_low; // [RULE8]
      DPT_SRC_COMM: ref_missing = comm_reference_lost; // [RULE9]
      default: ref_missing = 1'b0;
    endcase
    tick = tick_q == 32'(TICK_CYC - 1);
    tick_d = tick ? 32'h0 : tick_q + 32'h1;
    lwait_d = 11'h0;
    if (ref_missing && !loss_q)
      lwait_d = tick ? lwait_q + 11'h1 : lwait_q;
    loss_fire = ref_missing && !loss_q && tick &&
                lwait_q + 11'h1 >= wait_q; // [RULE10]
    loss_d = ref_missing && (loss_q || loss_fire);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tick_q <= 32'h0;
      lwait_q <= 11'h0;
      loss_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
      lwait_q <= lwait_d;
      loss_q <= loss_d;
    end
  end

  // ****************
  // Braking resistor duty
  // ****************
  logic brake_on_d, duty_ok;
  logic [7:0] cont_q, cont_d;
  logic [15:0] on_q, on_d, tot_q, tot_d;

  // Duty is decel ticks over all ticks since the sequence started
  always_comb begin
    duty_ok = !lim_q ||
              (23'(on_q) * 23'(PCT_SCALE) <=
               23'(tot_q) * 23'(pct_q)); // [RULE14] [RULE17]
    on_d = on_q;
    tot_d = tot_q;
    if (sequence_start) begin
      on_d = 16'h0;
      tot_d = 16'h0;
    end else if (tick && tot_q != 16'hffff) begin
      tot_d = tot_q + 16'h1;
      if (decel_active)
        on_d = on_q + 16'h1; // [RULE17]
    end
    cont_d = 8'h0;
    if (brake_request && (brake_on_q || cont_q == BRAKE_MAX_TICKS))
      cont_d = (tick && cont_q != BRAKE_MAX_TICKS) ? cont_q + 8'h1 : cont_q;
    brake_on_d = brake_request && duty_ok &&
                 cont_d != BRAKE_MAX_TICKS; // [RULE16]
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      brake_on_q <= 1'b0;
      cont_q <= 8'h0;
      on_q <= 16'h0;
      tot_q <= 16'h0;
    end else begin
      brake_on_q <= brake_on_d;
      cont_q <= cont_d;
      on_q <= on_d;
      tot_q <= tot_d;
    end
  end

  // ****************
  // Outputs
  // ****************
  assign resistor_enable = brake_on_q;
  assign inverter_output_enable =
    !(ext_trip_q | ovl_trip_q | loss_trip_q); // [RULE3] [RULE18]
  assign fault_display = ext_trip_q | ovl_trip_q | loss_trip_q;
  assign decel_stop_request = loss_q && mode_q == DPT_REACT_DECEL; // [RULE11]
  assign preset_freq_select = loss_q && mode_q == DPT_REACT_PRESET; // [RULE12]
  assign multifunction_digital_output =
    (digital_output_function_select == OUT_OVERLOAD && ovl_trip_q) || // [RULE6]
    (digital_output_function_select == OUT_LOSS && loss_q); // [RULE13]
  assign multifunction_relay_output =
    (relay_function_select == OUT_OVERLOAD && ovl_trip_q) || // [RULE6]
    (relay_function_select == OUT_LOSS && loss_q); // [RULE13]

  // ****************
  // Assertions
  // ****************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_EXT_NO_TRIP: assert property ( // [RULE3]
    (func_q[0] == FUNC_TRIP_NO && clean[0]) |=>
      ext_trip_q ##0 !inverter_output_enable)
    else $error("closed normally-open trip input did not trip");
  AST_EXT_NC_TRIP: assert property ( // [RULE4]
    (func_q[N_IN-1] == FUNC_TRIP_NC && !clean[N_IN-1]) |=> ext_trip_q)
    else $error("open normally-closed trip input did not trip");
  AST_OVL_TRIP: assert property ( // [RULE5]
    ovl_now |=> ovl_trip_q && fault_display)
    else $error("overload not latched");
  AST_OVL_ALARM: assert property ( // [RULE6]
    (ovl_trip_q && out_sel_q == OUT_OVERLOAD) |->
      multifunction_digital_output)
    else $error("overload alarm missing on digital output");
  AST_LOSS_SIG: assert property ( // [RULE13]
    (loss_q && rly_sel_q == OUT_LOSS) |-> multifunction_relay_output)
    else $error("loss alarm missing on relay");
  AST_LOSS_WAIT: assert property ( // [RULE10]
    $rose(loss_q) |-> $past(lwait_q) + 11'h1 >= $past(wait_q))
    else $error("loss declared before wait time");
  AST_CRIT_OFF: assert property ( // [RULE7]
    (crit_q == DPT_CRIT_OFF && src_q != DPT_SRC_COMM) |=> !$rose(loss_q))
    else $error("loss raised with check disabled");
  AST_FREERUN: assert property ( // [RULE11]
    (loss_fire && mode_q == DPT_REACT_FREERUN) |=> !inverter_output_enable)
    else $error("free run reaction did not cut output");
  AST_PRESET: assert property ( // [RULE12]
    (loss_fire && mode_q == DPT_REACT_PRESET && !wr_en) |=>
      preset_freq_select)
    else $error("preset not selected");
  AST_HOLD: assert property ( // [RULE18]
    (fault_display && !fault_rst) |=> fault_display)
    else $error("fault dropped without reset");
  AST_BRAKE_MAX: assert property ( // [RULE16]
    cont_q <= BRAKE_MAX_TICKS &&
    !(cont_q == BRAKE_MAX_TICKS && resistor_enable))
    else $error("resistor on beyond continuous limit");
  AST_DUTY: assert property ( // [RULE14]
    (lim_q && !duty_ok) |=> !resistor_enable)
    else $error("resistor on above duty limit");
  AST_WAIT_ONE: assert property (
    req && !ack_q |=> !avs_waitrequest)
    else $error("bus answer late");

  COV_EXT: cover property ($rose(ext_trip_q));
  COV_LOSS_DECEL: cover property ($rose(decel_stop_request));
  COV_BRAKE_CUT: cover property (brake_request && $fell(resistor_enable));
endmodule : dpt_trip

// file: rtl/dpt_pkg.sv
// Package: register map, field layout, reset values and timing for dpt
package dpt_pkg;
  // ****************
  // Register map
  // ****************
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_INFUNC_LO = 5'h04;
  localparam logic [4:0] ADDR_INFUNC_HI = 5'h08;
  localparam logic [4:0] ADDR_OUTSEL = 5'h0c;
  localparam logic [4:0] ADDR_LOSS_WAIT = 5'h10;
  localparam logic [4:0] ADDR_ANA_MIN = 5'h14;
  localparam logic [4:0] ADDR_BRAKE = 5'h18;
  localparam logic [4:0] ADDR_STATUS = 5'h1c;
  // ****************
  // Field positions
  // ****************
  localparam int CTRL_FAULT_RST = 0;
  localparam int CTRL_CRIT_LSB = 4;
  localparam int CTRL_MODE_LSB = 8;
  localparam int CTRL_SRC_LSB = 12;
  localparam int OUTSEL_RELAY_LSB = 8;
  localparam int ANA_CUR_LSB = 16;
  localparam int BRAKE_LIMIT_BIT = 8;
  localparam int FUNC_STRIDE = 8;
  // ****************
  // Codes and limits
  // ****************
  localparam logic [4:0] FUNC_MAX = 5'h1b;
  localparam logic [4:0] FUNC_TRIP_NO = 5'h12;
  localparam logic [4:0] FUNC_TRIP_NC = 5'h13;
  localparam logic [4:0] OUT_OVERLOAD = 5'h06;
  localparam logic [4:0] OUT_LOSS = 5'h0b;
  localparam logic [4:0] PCT_MAX = 5'h1e;
  localparam logic [4:0] PCT_RESET = 5'h0a;
  localparam logic [10:0] WAIT_MIN = 11'h001;
  localparam logic [10:0] WAIT_MAX = 11'h4b0;
  localparam logic [10:0] WAIT_RESET = 11'h00a;
  localparam logic [6:0] PCT_SCALE = 7'h64;
  // ****************
  // Timing
  // ****************
  localparam int CLK_MHZ = 250;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
  localparam int BRAKE_MAX_S = 15;
  localparam logic [7:0] BRAKE_MAX_TICKS = 8'(BRAKE_MAX_S * 1000 / TICK_MS);
  localparam int DEBOUNCE_CYCLES = 4;
  // ****************
  // Enumerations
  // ****************
  typedef enum logic [1:0] {
    DPT_CRIT_OFF, DPT_CRIT_HALF, DPT_CRIT_BELOW, DPT_CRIT_RSVD
  } dpt_crit_e;
  typedef enum logic [1:0] {
    DPT_REACT_CONT, DPT_REACT_FREERUN, DPT_REACT_DECEL, DPT_REACT_PRESET
  } dpt_react_e;
  typedef enum logic [1:0] {
    DPT_SRC_VOLT, DPT_SRC_CURR, DPT_SRC_BOTH, DPT_SRC_COMM
  } dpt_src_e;
endpackage : dpt_pkg

// file: rtl/dpt_debounce.sv
// Two-flop synchroniser with stable-count filter for one contact
`timescale 1ns/1ps
module dpt_debounce #(
  parameter int STABLE = dpt_pkg::DEBOUNCE_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Contact
  input wire logic raw_in,
  output logic clean_out
);
  import dpt_pkg::*;
  logic meta_q, sync_q, out_q, out_d;
  logic [3:0] cnt_q, cnt_d;

  always_comb begin
    out_d = out_q;
    cnt_d = 4'h0;
    if (sync_q != out_q) begin
      cnt_d = cnt_q + 4'h1;
      if (cnt_q == 4'(STABLE - 1)) begin
        out_d = sync_q;
        cnt_d = 4'h0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      out_q <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
      out_q <= out_d;
      cnt_q <= cnt_d;
    end
  end

  assign clean_out = out_q;
endmodule : dpt_debounce

// file: tb/dpt_far_side.sv
// Far-side model: trip contacts, load current and reference levels
`timescale 1ns/1ps
module dpt_far_side (
  // Clock
  input wire logic core_clk,
  // Commands from the bench
  input wire logic [7:0] contact_cmd,
  input wire logic [7:0] glitch_cmd,
  input wire logic [15:0] load_cmd,
  input wire logic [11:0] volt_cmd,
  input wire logic [11:0] amp_cmd,
  input wire logic comm_cmd,
  // Terminal side
  output logic [7:0] terminal_in,
  output logic [15:0] output_current,
  output logic [11:0] analog_voltage_reference,
  output logic [11:0] analog_current_reference,
  output logic comm_reference_lost
);
  // ****************
  // Levels
  // ****************
  // Known levels before the first edge, so no input floats at time zero
  initial begin
    terminal_in = 8'h00;
    output_current = 16'h0000;
    analog_voltage_reference = 12'h800;
    analog_current_reference = 12'h800;
    comm_reference_lost = 1'b0;
  end
  // A glitch flips a contact for one cycle only
  always @(posedge core_clk) begin
    terminal_in <= contact_cmd ^ glitch_cmd;
    output_current <= load_cmd;
    analog_voltage_reference <= volt_cmd;
    analog_current_reference <= amp_cmd;
    comm_reference_lost <= comm_cmd;
  end
endmodule : dpt_far_side

// file: tb/drive_protection_trip_logic_tb.sv
// Self-checking bench for the drive protection trip logic
`timescale 1ns/1ps
module drive_protection_trip_logic_tb;
  import dpt_pkg::*;
  // ****************
  // Signals
  // ****************
  localparam int TICK = 20;
  localparam int LIMIT = 20000;
  localparam logic [31:0] LC_CTRL [9] = '{32'h20, 32'h20, 32'h10, 32'h10,
    32'h2020, 32'h2020, 32'h3020, 32'h1020, 32'h0};
  localparam logic [11:0] LC_V [9] = '{99, 100, 49, 50, 800, 99, 800, 800, 0};
  localparam logic [11:0] LC_A [9] = '{800, 800, 800, 800, 199, 800, 800,
    199, 800};
  localparam logic LC_C [9] = '{0, 0, 0, 0, 0, 0, 1, 0, 0};
  localparam logic LC_EXP [9] = '{1, 0, 1, 0, 1, 1, 1, 1, 0};
  logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0] terminal_in, contact_cmd, glitch_cmd;
  logic [15:0] output_current, load_cmd, rated_current;
  logic [11:0] volt_ref, amp_ref, volt_cmd, amp_cmd;
  logic comm_lost, comm_cmd, sequence_start, decel_active, brake_request;
  logic resistor_enable, inverter_output_enable, decel_stop_request;
  logic preset_freq_select, fault_display, mf_dout, mf_relay;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;

  dpt_far_side far (.core_clk(core_clk), .contact_cmd(contact_cmd),
    .glitch_cmd(glitch_cmd), .load_cmd(load_cmd), .volt_cmd(volt_cmd),
    .amp_cmd(amp_cmd), .comm_cmd(comm_cmd), .terminal_in(terminal_in),
    .output_current(output_current), .analog_voltage_reference(volt_ref),
    .analog_current_reference(amp_ref), .comm_reference_lost(comm_lost));

  dpt_trip #(.TICK_CYC(TICK)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .terminal_in(terminal_in),
    .output_current(output_current), .rated_current(rated_current),
    .analog_voltage_reference(volt_ref), .analog_current_reference(amp_ref),
    .comm_reference_lost(comm_lost), .sequence_start(sequence_start),
    .decel_active(decel_active), .brake_request(brake_request),
    .resistor_enable(resistor_enable),
    .inverter_output_enable(inverter_output_enable),
    .decel_stop_request(decel_stop_request),
    .preset_freq_select(preset_freq_select), .fault_display(fault_display),
    .multifunction_digital_output(mf_dout),
    .multifunction_relay_output(mf_relay));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Hang guard: the whole run needs well under half of this
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end
  // ****************
  // Tasks
  // ****************
  task summarize();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  task check_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : check_word
  task check_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask : check_bit
  // Request held until waitrequest is sampled low, released after it
  task bus_write(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : bus_write
  task reg_chk(input logic [4:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    check_word(rd, exp);
  endtask : reg_chk
  // Let the edge's updates land before looking
  task settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle
  // ****************
  // Tests
  // ****************
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    contact_cmd = 8'h00;
    glitch_cmd = 8'h00;
    load_cmd = 16'h0010;
    rated_current = 16'h0100;
    volt_cmd = 12'h320;
    amp_cmd = 12'h320;
    comm_cmd = 1'b0;
    sequence_start = 1'b0;
    decel_active = 1'b0;
    brake_request = 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    settle(1);
    check_bit(inverter_output_enable, 1'b1);
    reg_chk(ADDR_LOSS_WAIT, 32'h0000000a);
    reg_chk(ADDR_BRAKE, 32'h0000010a);
    bus_write(ADDR_STATUS, 32'hffffffff);
    reg_chk(ADDR_STATUS, 32'h00000008);
    bus_write(ADDR_INFUNC_LO, 32'h1b1a0100);
    reg_chk(ADDR_INFUNC_LO, 32'h1b1a0100);
    bus_write(ADDR_INFUNC_LO, 32'h1c1c1c1c);
    reg_chk(ADDR_INFUNC_LO, 32'h1b1a0100);
    // Normally-open trip on input 1, with a glitch first
    bus_write(ADDR_INFUNC_LO, 32'h00000012);
    @(posedge core_clk) glitch_cmd <= 8'h01;
    @(posedge core_clk) glitch_cmd <= 8'h00;
    settle(15);
    check_bit(fault_display, 1'b0);
    @(posedge core_clk) contact_cmd <= 8'h01;
    settle(14);
    check_bit(fault_display, 1'b1);
    check_bit(inverter_output_enable, 1'b0);
    reg_chk(ADDR_STATUS, 32'h00000001);
    @(posedge core_clk) contact_cmd <= 8'h00;
    settle(14);
    check_bit(fault_display, 1'b1);
    bus_write(ADDR_CTRL, 32'h00000001);
    settle(2);
    check_bit(fault_display, 1'b0);
    check_bit(inverter_output_enable, 1'b1);
    // Normally-closed trip on input 8
    @(posedge core_clk) contact_cmd <= 8'h80;
    settle(14);
    bus_write(ADDR_INFUNC_HI, 32'h13000000);
    settle(14);
    check_bit(fault_display, 1'b0);
    @(posedge core_clk) contact_cmd <= 8'h00;
    settle(14);
    check_bit(fault_display, 1'b1);
    check_bit(inverter_output_enable, 1'b0);
    bus_write(ADDR_INFUNC_HI, 32'h00000000);
    bus_write(ADDR_CTRL, 32'h00000001);
    settle(2);
    check_bit(fault_display, 1'b0);
    // Overload: equal current is no trip, one above is
    bus_write(ADDR_OUTSEL, 32'h00000606);
    @(posedge core_clk) load_cmd <= 16'h0100;
    settle(5);
    check_bit(fault_display, 1'b0);
    @(posedge core_clk) load_cmd <= 16'h0101;
    settle(5);
    check_bit(mf_dout, 1'b1);
    check_bit(mf_relay, 1'b1);
    reg_chk(ADDR_STATUS, 32'h00000002);
    @(posedge core_clk) load_cmd <= 16'h0010;
    bus_write(ADDR_CTRL, 32'h00000001);
    settle(2);
    check_bit(mf_dout, 1'b0);
    // Reference loss: criteria and sources from the table
    bus_write(ADDR_OUTSEL, 32'h00000b0b);
    bus_write(ADDR_ANA_MIN, 32'h00c80064);
    bus_write(ADDR_LOSS_WAIT, 32'h00000001);
    for (int i = 0; i < 9; i++) begin
      bus_write(ADDR_CTRL, LC_CTRL[i]);
      volt_cmd <= LC_V[i];
      amp_cmd <= LC_A[i];
      comm_cmd <= LC_C[i];
      settle(3 * TICK + 10);
      check_bit(mf_dout, LC_EXP[i]);
      check_bit(mf_relay, LC_EXP[i]);
      @(posedge core_clk) volt_cmd <= 12'h320;
      amp_cmd <= 12'h320;
      comm_cmd <= 1'b0;
      settle(5);
      check_bit(mf_dout, 1'b0);
    end
    // Wait time of three ticks, out-of-range values refused
    bus_write(ADDR_LOSS_WAIT, 32'h00000003);
    bus_write(ADDR_LOSS_WAIT, 32'h00000000);
    bus_write(ADDR_LOSS_WAIT, 32'h000004b1);
    reg_chk(ADDR_LOSS_WAIT, 32'h00000003);
    bus_write(ADDR_CTRL, 32'h00000020);
    @(posedge core_clk) volt_cmd <= 12'd99;
    settle(35);
    check_bit(mf_dout, 1'b0);
    settle(40);
    check_bit(mf_dout, 1'b1);
    @(posedge core_clk) volt_cmd <= 12'h320;
    bus_write(ADDR_LOSS_WAIT, 32'h00000001);
    // Every loss reaction mode
    for (int m = 0; m < 4; m++) begin
      bus_write(ADDR_CTRL, 32'h00000020 | (m << CTRL_MODE_LSB));
      volt_cmd <= 12'd99;
      settle(3 * TICK + 10);
      check_bit(decel_stop_request, 1'(m == 2));
      check_bit(preset_freq_select, 1'(m == 3));
      check_bit(inverter_output_enable, 1'(m != 1));
      @(posedge core_clk) volt_cmd <= 12'h320;
      settle(5);
      bus_write(ADDR_CTRL, 32'h00000021);
    end
    // Braking resistor: no limit, then the 15 s cut-off
    bus_write(ADDR_BRAKE, 32'h0000011f);
    reg_chk(ADDR_BRAKE, 32'h0000010a);
    bus_write(ADDR_BRAKE, 32'h0000000a);
    @(posedge core_clk) sequence_start <= 1'b1;
    @(posedge core_clk) sequence_start <= 1'b0;
    brake_request <= 1'b1;
    settle(10);
    check_bit(resistor_enable, 1'b1);
    settle(2900);
    check_bit(resistor_enable, 1'b1);
    settle(140);
    check_bit(resistor_enable, 1'b0);
    @(posedge core_clk) brake_request <= 1'b0;
    settle(3);
    @(posedge core_clk) brake_request <= 1'b1;
    settle(5);
    check_bit(resistor_enable, 1'b1);
    // Limit on with zero percent: the resistor must drop out
    @(posedge core_clk) brake_request <= 1'b0;
    bus_write(ADDR_BRAKE, 32'h00000100);
    @(posedge core_clk) sequence_start <= 1'b1;
    @(posedge core_clk) sequence_start <= 1'b0;
    decel_active <= 1'b1;
    brake_request <= 1'b1;
    settle(100);
    check_bit(resistor_enable, 1'b0);
    summarize();
  end
endmodule : drive_protection_trip_logic_tb
